// ### hdl/channel_error_output_shutdown.v
// Channel error output shutdown controller with APB registers
// Function
// - Shutdown enabled and channel error seen: affected outputs go off at once.
// - A detected channel error is passed on to the other channel units.
// - Shutdown switch works only with a single CPU; treated as off in multi-CPU systems.
// - Basic CPU types: shutdown applies only to modules of 32 points or less.
// - Stations still linked to master are upstream and behave like the master.
// - Cut-off stations hold, except shutdown switch with reset setting: those shut down.
// - Hold switch upstream: stop policy shuts down or holds per setting; run continues.
// - Shutdown switch upstream: reset shuts down; hold holds on stop, runs on run.
// - Contact A closes, B opens when the switch is set, or on shutdown or hold while connected.
// - Hold selected and channel secured: station keeps running under run policy.
`timescale 1ns/1ps
`include "channel_error_regs.vh"
module channel_error_output_shutdown #(
  parameter NUM_MODULES = 8
) (
  input wire core_clk,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire localChannelError,
  input wire remoteChannelError,
  input wire connectedToMaster,
  input wire multiCpu,
  output reg channelErrorOut,
  output reg [2*NUM_MODULES-1:0] moduleCmd,
  output reg fault_contact_a,
  output reg fault_contact_b
);

  // ===================================================================
  // Control and configuration registers
  reg switch_q;
  reg switch_d;
  reg holdSet_q;
  reg holdSet_d;
  reg policyRun_q;
  reg policyRun_d;
  reg basicCpu_q;
  reg basicCpu_d;
  reg [NUM_MODULES-1:0] wideMask_q;
  reg [NUM_MODULES-1:0] wideMask_d;
  reg [`CE_COUNT_WIDTH-1:0] errCount_q;
  reg [`CE_COUNT_WIDTH-1:0] errCount_d;

  // ===================================================================
  // APB access decode
  wire access;
  wire writeDone;
  wire readPhase;
  wire hitCtrl;
  wire hitWide;
  wire hitStatus;
  wire hitCount;
  wire hitCmd;
  wire mapped;
  wire clearReq;
  wire countClear;

  assign access = psel & penable;
  assign writeDone = access & pready & pwrite & ~pslverr;
  assign readPhase = access & ~pready;
  assign hitCtrl = (paddr == `CE_CTRL_OFFSET);
  assign hitWide = (paddr == `CE_WIDE_OFFSET);
  assign hitStatus = (paddr == `CE_STATUS_OFFSET);
  assign hitCount = (paddr == `CE_COUNT_OFFSET);
  assign hitCmd = (paddr == `CE_CMD_OFFSET);
  assign mapped = hitCtrl | hitWide | hitStatus | hitCount | hitCmd;
  assign clearReq = writeDone & hitStatus & pstrb[0] & pwdata[`CE_STAT_ERR_BIT];
  assign countClear = writeDone & hitCount & pstrb[0];

  // ===================================================================
  // Error tracking and propagation
  wire errorActive;
  wire localSeen;
  wire remoteSeen;
  wire newError;

  channel_error_tracker tracker (
    .core_clk(core_clk),
    .rstn(rstn),
    .localError(localChannelError),
    .remoteError(remoteChannelError),
    .clearReq(clearReq),
    .errorActive(errorActive),
    .localSeen(localSeen),
    .remoteSeen(remoteSeen),
    .newError(newError)
  );

  // ===================================================================
  // Station outcome
  wire effSwitch;
  wire [1:0] stationOutcome;
  wire contactA;

  assign effSwitch = switch_q & ~multiCpu;

  outcome_table table_inst (
    .errorActive(errorActive),
    .connected(connectedToMaster),
    .switchOn(effSwitch),
    .holdSetting(holdSet_q),
    .policyRun(policyRun_q),
    .outcome(stationOutcome),
    .contactA(contactA)
  );

  // ===================================================================
  // Per module command with width limit
  wire [2*NUM_MODULES-1:0] cmdNext;

  genvar m;
  generate
    for (m = 0; m < NUM_MODULES; m = m + 1) begin : gModule
      wire limited;
      assign limited = basicCpu_q & wideMask_q[m] & (stationOutcome == `CE_OUT_SHUTDOWN);
      assign cmdNext[2*m+1:2*m] = limited ? `CE_OUT_HOLD : stationOutcome;
    end
  endgenerate

  // ===================================================================
  // Register next values
  always @* begin
    switch_d = switch_q;
    holdSet_d = holdSet_q;
    policyRun_d = policyRun_q;
    basicCpu_d = basicCpu_q;
    wideMask_d = wideMask_q;
    errCount_d = errCount_q;
    if (writeDone && hitCtrl && pstrb[0]) begin
      switch_d = pwdata[`CE_CTRL_SWITCH_BIT];
      holdSet_d = pwdata[`CE_CTRL_HOLDSET_BIT];
      policyRun_d = pwdata[`CE_CTRL_RUN_BIT];
      basicCpu_d = pwdata[`CE_CTRL_BASIC_BIT];
    end
    if (writeDone && hitWide) begin
      wideMask_d = pwdata[NUM_MODULES-1:0];
    end
    if (newError) begin
      errCount_d = errCount_q + {{(`CE_COUNT_WIDTH-1){1'b0}}, 1'b1};
    end else if (countClear) begin
      errCount_d = {`CE_COUNT_WIDTH{1'b0}};
    end
  end

  // ===================================================================
  // Read data mux
  reg [31:0] readData;

  always @* begin
    readData = 32'h00000000;
    case (1'b1)
      hitCtrl: begin
        readData[`CE_CTRL_SWITCH_BIT] = switch_q;
        readData[`CE_CTRL_HOLDSET_BIT] = holdSet_q;
        readData[`CE_CTRL_RUN_BIT] = policyRun_q;
        readData[`CE_CTRL_BASIC_BIT] = basicCpu_q;
      end
      hitWide: begin
        readData[NUM_MODULES-1:0] = wideMask_q;
      end
      hitStatus: begin
        readData[`CE_STAT_ERR_BIT] = errorActive;
        readData[`CE_STAT_CONN_BIT] = connectedToMaster;
        readData[`CE_STAT_CONTA_BIT] = fault_contact_a;
        readData[`CE_STAT_CONTB_BIT] = fault_contact_b;
        readData[`CE_STAT_OUT_LSB+1:`CE_STAT_OUT_LSB] = stationOutcome;
        readData[`CE_STAT_LOCAL_BIT] = localSeen;
        readData[`CE_STAT_REMOTE_BIT] = remoteSeen;
        readData[`CE_STAT_MULTI_BIT] = multiCpu;
      end
      hitCount: begin
        readData[`CE_COUNT_WIDTH-1:0] = errCount_q;
      end
      hitCmd: begin
        readData[2*NUM_MODULES-1:0] = moduleCmd;
      end
      default: begin
        readData = 32'h00000000;
      end
    endcase
  end

  // ===================================================================
  // Registers and outputs
  always @(posedge core_clk) begin
    if (!rstn) begin
      switch_q <= `CE_SWITCH_RESET;
      holdSet_q <= `CE_HOLDSET_RESET;
      policyRun_q <= `CE_RUN_RESET;
      basicCpu_q <= `CE_BASIC_RESET;
      wideMask_q <= {NUM_MODULES{1'b0}};
      errCount_q <= {`CE_COUNT_WIDTH{1'b0}};
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      channelErrorOut <= 1'b0;
      moduleCmd <= {2*NUM_MODULES{1'b0}};
      fault_contact_a <= 1'b0;
      fault_contact_b <= 1'b1;
    end else begin
      switch_q <= switch_d;
      holdSet_q <= holdSet_d;
      policyRun_q <= policyRun_d;
      basicCpu_q <= basicCpu_d;
      wideMask_q <= wideMask_d;
      errCount_q <= errCount_d;
      pready <= readPhase;
      pslverr <= readPhase & ~mapped;
      prdata <= (readPhase & ~pwrite) ? readData : 32'h00000000;
      channelErrorOut <= localChannelError | remoteChannelError | errorActive;
      moduleCmd <= cmdNext;
      fault_contact_a <= contactA;
      fault_contact_b <= ~contactA;
    end
  end

endmodule // channel_error_output_shutdown

// ### hdl/channel_error_regs.vh
// Register offsets, field positions, reset values and outcome codes
`ifndef CHANNEL_ERROR_REGS_VH
`define CHANNEL_ERROR_REGS_VH

// =====================================================================
// Register byte offsets
`define CE_CTRL_OFFSET 12'h000
`define CE_WIDE_OFFSET 12'h004
`define CE_STATUS_OFFSET 12'h008
`define CE_COUNT_OFFSET 12'h00c
`define CE_CMD_OFFSET 12'h010

// =====================================================================
// Control register fields
`define CE_CTRL_SWITCH_BIT 0
`define CE_CTRL_HOLDSET_BIT 1
`define CE_CTRL_RUN_BIT 2
`define CE_CTRL_BASIC_BIT 3
`define CE_CTRL_WIDTH 4

// Control reset values: shutdown switch on, reset setting, run policy
`define CE_SWITCH_RESET 1'b1
`define CE_HOLDSET_RESET 1'b0
`define CE_RUN_RESET 1'b1
`define CE_BASIC_RESET 1'b0

// =====================================================================
// Status register fields
`define CE_STAT_ERR_BIT 0
`define CE_STAT_CONN_BIT 1
`define CE_STAT_CONTA_BIT 2
`define CE_STAT_CONTB_BIT 3
`define CE_STAT_OUT_LSB 4
`define CE_STAT_LOCAL_BIT 6
`define CE_STAT_REMOTE_BIT 7
`define CE_STAT_MULTI_BIT 8

// =====================================================================
// Output module outcome codes
`define CE_OUT_NORMAL 2'h0
`define CE_OUT_SHUTDOWN 2'h1
`define CE_OUT_HOLD 2'h2

// Counter width for detected errors
`define CE_COUNT_WIDTH 16

`endif

// ### hdl/channel_error_tracker.v
// Sticky channel error latch with local and propagated sources
`timescale 1ns/1ps
module channel_error_tracker (
  input wire core_clk,
  input wire rstn,
  input wire localError,
  input wire remoteError,
  input wire clearReq,
  output reg errorActive,
  output reg localSeen,
  output reg remoteSeen,
  output wire newError
);

  // ===================================================================
  // Rising edge of the OR of both error sources
  reg anyPrev_q;
  wire anyError;

  assign anyError = localError | remoteError;
  assign newError = anyError & ~anyPrev_q;

  // ===================================================================
  // Sticky flags, a new event wins over a clear
  always @(posedge core_clk) begin
    if (!rstn) begin
      anyPrev_q <= 1'b0;
      errorActive <= 1'b0;
      localSeen <= 1'b0;
      remoteSeen <= 1'b0;
    end else begin
      anyPrev_q <= anyError;
      errorActive <= anyError | (errorActive & ~clearReq);
      localSeen <= localError | (localSeen & ~clearReq);
      remoteSeen <= remoteError | (remoteSeen & ~clearReq);
    end
  end

endmodule // channel_error_tracker

// ### hdl/outcome_table.v
// Output outcome and fault contact decision for one station
`timescale 1ns/1ps
`include "channel_error_regs.vh"
module outcome_table (
  input wire errorActive,
  input wire connected,
  input wire switchOn,
  input wire holdSetting,
  input wire policyRun,
  output reg [1:0] outcome,
  output reg contactA
);

  // ===================================================================
  // Decision table
  always @* begin
    outcome = `CE_OUT_NORMAL;
    contactA = 1'b0;
    if (errorActive) begin
      if (connected) begin
        if (switchOn) begin
          if (!holdSetting) begin
            outcome = `CE_OUT_SHUTDOWN;
          end else if (!policyRun) begin
            outcome = `CE_OUT_HOLD;
          end else begin
            outcome = `CE_OUT_NORMAL;
          end
          contactA = 1'b1;
        end else begin
          if (policyRun) begin
            outcome = `CE_OUT_NORMAL;
            contactA = 1'b0;
          end else begin
            outcome = holdSetting ? `CE_OUT_HOLD : `CE_OUT_SHUTDOWN;
            contactA = 1'b1;
          end
        end
      end else begin
        if (switchOn && !holdSetting) begin
          outcome = `CE_OUT_SHUTDOWN;
        end else begin
          outcome = `CE_OUT_HOLD;
        end
        contactA = switchOn;
      end
    end
  end

endmodule // outcome_table

// ### tb/neighbour_station.sv
// Neighbour unit on the channel
`timescale 1ns/1ps
module neighbour_station (
  input wire core_clk,
  input wire rstn,
  input wire breakReq,
  input wire errFromDut,
  output reg remoteErr,
  output reg heardErr
);
  always @(posedge core_clk) begin
    if (!rstn) begin
      remoteErr <= 1'b0;
      heardErr <= 1'b0;
    end else begin
      remoteErr <= breakReq;
      heardErr <= errFromDut;
    end
  end
endmodule // neighbour_station

// ### tb/channel_error_checker.sv
// Checker of error path, outcomes and fault contacts
`timescale 1ns/1ps
module channel_error_checker #(parameter NUM_MODULES = 8) (
  input wire core_clk, input wire rstn, input wire psel,
  input wire localChannelError, input wire remoteChannelError,
  input wire connectedToMaster, input wire multiCpu, input wire channelErrorOut,
  input wire [2*NUM_MODULES-1:0] moduleCmd,
  input wire fault_contact_a, input wire fault_contact_b
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // =====================================================
  // Assertions
  chk_contact_pair: assert property (fault_contact_b == !fault_contact_a) else $error("contacts not opposite");
  chk_error_out: assert property ((localChannelError || remoteChannelError) |=> channelErrorOut)
    else $error("error not passed on");
  chk_error_stays: assert property (channelErrorOut && !psel && !$past(psel) |=> channelErrorOut)
    else $error("error dropped");
  chk_quiet_normal: assert property (!channelErrorOut && !$past(channelErrorOut) |->
    moduleCmd == '0 && !fault_contact_a) else $error("outputs off without error");
  chk_linked_open: assert property ($past(connectedToMaster) && connectedToMaster && !fault_contact_a |->
    moduleCmd == '0) else $error("linked open contact not normal");
  chk_cutoff_held: assert property (!$past(connectedToMaster) && $past(channelErrorOut) && channelErrorOut |->
    moduleCmd[1:0] != 2'h0) else $error("cut off station kept running");
  chk_multi_cpu: assert property (multiCpu && $past(multiCpu) && fault_contact_a |->
    moduleCmd[1:0] != 2'h0) else $error("multi cpu outcome");
  chk_rose_contact: assert property ($rose(fault_contact_a) |-> $past(channelErrorOut))
    else $error("contact closed without error");
endmodule // channel_error_checker
bind channel_error_output_shutdown channel_error_checker #(.NUM_MODULES(NUM_MODULES)) chk (.core_clk(core_clk),
  .rstn(rstn), .psel(psel), .localChannelError(localChannelError), .remoteChannelError(remoteChannelError),
  .connectedToMaster(connectedToMaster), .multiCpu(multiCpu), .channelErrorOut(channelErrorOut),
  .moduleCmd(moduleCmd), .fault_contact_a(fault_contact_a), .fault_contact_b(fault_contact_b));

// ### tb/testbench.sv
// Self-checking bench for the channel error output shutdown block
`timescale 1ns/1ps
module testbench;
  localparam NM = 4;
  logic core_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, se, localChannelError = 1'b0, remoteChannelError, connectedToMaster = 1'b1;
  logic multiCpu = 1'b0, breakReq = 1'b0, heardErr, channelErrorOut, fa, fb;
  logic [2*NM-1:0] moduleCmd;
  logic [2:0] e;
  integer n_errors = 0, comparisons = 0, cycles = 0, i;
  channel_error_output_shutdown #(.NUM_MODULES(NM)) dut (.core_clk(core_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .localChannelError(localChannelError),
    .remoteChannelError(remoteChannelError), .connectedToMaster(connectedToMaster), .multiCpu(multiCpu),
    .channelErrorOut(channelErrorOut), .moduleCmd(moduleCmd), .fault_contact_a(fa), .fault_contact_b(fb));
  neighbour_station peer (.core_clk(core_clk), .rstn(rstn), .breakReq(breakReq), .errFromDut(channelErrorOut),
    .remoteErr(remoteChannelError), .heardErr(heardErr));
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_errors = n_errors + 1;
      $display("mismatch at %0t: timeout", $time);
      print_verdict;
    end
  end
  // =====================================================
  // Shared tasks
  task print_verdict;
    begin
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input logic ok, input string m);
    begin
      comparisons = comparisons + 1;
      if (ok !== 1'b1) begin
        n_errors = n_errors + 1;
        $display("mismatch at %0t: %s", $time, m);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge core_clk);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    begin
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(negedge core_clk);
      while (pready !== 1'b1) @(negedge core_clk);
      rd = prdata;
      se = pslverr;
      @(posedge core_clk);
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // Returns contact A and station outcome
  function automatic logic [2:0] expect_out(input logic c, input logic s, input logic h, input logic r);
    if (c && s) expect_out = {1'b1, !h ? 2'h1 : (r ? 2'h0 : 2'h2)};
    else if (c) expect_out = r ? 3'h0 : {1'b1, h ? 2'h2 : 2'h1};
    else expect_out = {s, (s && !h) ? 2'h1 : 2'h2};
  endfunction
  task clr;
    begin
      localChannelError <= 1'b0;
      breakReq <= 1'b0;
      tick(3);
      apb(1'b1, 12'h008, 32'h1);
      apb(1'b1, 12'h00c, 32'h0);
      apb(1'b1, 12'h000, 32'h5);
      tick(3);
      chk(channelErrorOut === 1'b0 && moduleCmd === '0 && heardErr === 1'b0, "not cleared");
    end
  endtask
  // =====================================================
  // Scenarios
  task t_reset;
    begin
      apb(1'b0, 12'h000, 32'h0);
      chk(rd === 32'h5 && se === 1'b0, "ctrl reset");
      apb(1'b0, 12'h008, 32'h0);
      chk(rd[3:2] === 2'b10 && moduleCmd === '0, "idle contacts");
    end
  endtask
  task t_table;
    begin
      // Daisy chain wiring only, so the shutdown switch may be set
      localChannelError <= 1'b1;
      for (i = 0; i < 16; i = i + 1) begin
        connectedToMaster <= i[3];
        apb(1'b1, 12'h000, {29'h0, i[2:0]});
        tick(3);
        e = expect_out(i[3], i[0], i[1], i[2]);
        chk(moduleCmd === {NM{e[1:0]}} && fa === e[2] && fb === !e[2], "table");
      end
      connectedToMaster <= 1'b1;
      multiCpu <= 1'b1;
      apb(1'b1, 12'h000, 32'h5);
      tick(3);
      chk(moduleCmd === 8'h00 && fa === 1'b0, "multi run");
      apb(1'b1, 12'h000, 32'h1);
      tick(3);
      chk(moduleCmd === 8'h55 && fa === 1'b1, "multi stop");
      multiCpu <= 1'b0;
      apb(1'b1, 12'h004, 32'h1);
      apb(1'b1, 12'h000, 32'h9);
      tick(3);
      chk(moduleCmd === 8'h56, "wide module");
      apb(1'b1, 12'h004, 32'h0);
    end
  endtask
  task t_fast;
    begin
      clr;
      localChannelError <= 1'b1;
      tick(2);
      chk(channelErrorOut === 1'b1, "not passed on");
      tick(1);
      chk(moduleCmd === 8'h55 && fa === 1'b1, "slow shutdown");
      chk(heardErr === 1'b1, "neighbour not told");
      apb(1'b0, 12'h010, 32'h0);
      chk(rd === 32'h55, "cmd readback");
      apb(1'b0, 12'h014, 32'h0);
      chk(se === 1'b1 && rd === 32'h0, "unmapped");
    end
  endtask
  task t_remote;
    begin
      clr;
      breakReq <= 1'b1;
      tick(4);
      chk(moduleCmd === 8'h55, "remote shutdown");
      apb(1'b0, 12'h008, 32'h0);
      chk(rd[7:6] === 2'b10 && rd[0] === 1'b1, "remote seen");
      apb(1'b0, 12'h00c, 32'h0);
      chk(rd === 32'h1, "error count");
    end
  endtask
  initial begin
    tick(4);
    rstn <= 1'b1;
    t_reset;
    t_table;
    t_fast;
    t_remote;
    print_verdict;
  end
endmodule // testbench
